// >>> inc/vip_pkg.sv
package vip_pkg;
	localparam int VIP_NSRC      = 32;
	localparam int VIP_IDX_W     = 5;
	localparam int VIP_PRIO_W    = 8;
	localparam int VIP_IMPL_W    = 3;
	localparam int VIP_GROUP_W   = 3;
	localparam logic [2:0] VIP_GROUP_RST = 3'h3;
	localparam logic [2:0] VIP_IMPL_BITS = 3'h3;
	localparam logic [2:0] VIP_LVL_IDLE  = 3'h7;
	typedef logic [VIP_IMPL_W-1:0] vip_lvl_t;
	typedef enum logic [1:0] {
		VIP_ST_IDLE   = 2'b01,
		VIP_ST_ACTIVE = 2'b10
	} vip_state_e;
endpackage

// >>> design/vip_prio_mem.sv
`timescale 1ns/10ps
module vip_prio_mem
	import vip_pkg::*;
(
	input  wire logic                    mclk,      // System clock
	input  wire logic                    reset_n,   // Async reset, active low
	input  wire logic                    wr_en,     // Priority write strobe
	input  wire logic [VIP_IDX_W-1:0]    wr_idx,    // Source written
	input  wire logic [VIP_PRIO_W-1:0]   wr_data,   // Full priority byte
	input  wire logic [VIP_IDX_W-1:0]    rd_idx,    // Source read
	output logic      [VIP_PRIO_W-1:0]   rd_data,   // Registered read byte
	output logic      [VIP_NSRC*VIP_IMPL_W-1:0] lvl_flat // All implemented levels
);
	vip_lvl_t                  lvl_reg  [VIP_NSRC];
	vip_lvl_t                  lvl_next [VIP_NSRC];
	logic     [VIP_PRIO_W-1:0] rd_reg;
	logic     [VIP_PRIO_W-1:0] rd_next;

	genvar g;
	generate
		for (g = 0; g < VIP_NSRC; g++) begin : g_ent
			always_comb begin
				lvl_next[g] = lvl_reg[g];
				if (wr_en && wr_idx == VIP_IDX_W'(g))
					lvl_next[g] = wr_data[VIP_PRIO_W-1 -: VIP_IMPL_W];
			end
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n)
					lvl_reg[g] <= '0;
				else
					lvl_reg[g] <= lvl_next[g];
			end
			assign lvl_flat[g*VIP_IMPL_W +: VIP_IMPL_W] = lvl_reg[g];
		end
	endgenerate

	// Unimplemented low bits read back as zero
	always_comb begin
		rd_next = {lvl_reg[rd_idx], {(VIP_PRIO_W-VIP_IMPL_W){1'b0}}};
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rd_reg <= '0;
		else
			rd_reg <= rd_next;
	end
	assign rd_data = rd_reg;
endmodule

// >>> design/vip_top.sv
`timescale 1ns/10ps
module vip_top
	import vip_pkg::*;
(
	input  wire logic                  mclk,          // System clock
	input  wire logic                  reset_n,       // Async reset, active low
	input  wire logic [VIP_NSRC-1:0]   src_irq,       // Peripheral request levels
	input  wire logic                  en_set,        // Pulse: enable source en_idx
	input  wire logic                  en_clr,        // Pulse: disable source en_idx
	input  wire logic [VIP_IDX_W-1:0]  en_idx,        // Source for enable change
	input  wire logic                  prio_wr,       // Pulse: write priority byte
	input  wire logic [VIP_IDX_W-1:0]  prio_idx,      // Source for priority access
	input  wire logic [VIP_PRIO_W-1:0] prio_wdata,    // Priority byte
	output logic      [VIP_PRIO_W-1:0] prio_rdata,    // Priority read, one cycle late
	input  wire logic                  group_wr,      // Pulse: write grouping
	input  wire logic [2:0]            group_wdata,   // Preemptive bit count
	output logic      [2:0]            group_rdata,   // Grouping read back
	output logic      [VIP_NSRC-1:0]   enable_rdata,  // Enable bits read back
	output logic                       irq_req,       // Request to core, level
	output logic      [VIP_IDX_W-1:0]  irq_vec,       // Source to service
	input  wire logic                  irq_ack,       // Core takes best_idx, not irq_vec
	input  wire logic                  irq_done,      // Core ends active handler
	output logic                       irq_active,    // Handler in progress
	output logic      [VIP_IDX_W-1:0]  active_vec     // Source being handled
);
	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	logic [VIP_NSRC-1:0] en_reg;
	logic [VIP_NSRC-1:0] en_next;
	logic [2:0]          group_reg;
	logic [2:0]          group_next;
	logic [VIP_NSRC*VIP_IMPL_W-1:0] lvl_flat;

	always_comb begin
		en_next    = en_reg;
		group_next = group_reg;
		// Only the controller copy of the enable moves; peripheral enables are outside
		if (en_set)
			en_next[en_idx] = 1'b1;
		if (en_clr)
			en_next[en_idx] = 1'b0;
		if (group_wr)
			group_next = group_wdata;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			en_reg    <= '0;
			group_reg <= VIP_GROUP_RST;
		end else begin
			en_reg    <= en_next;
			group_reg <= group_next;
		end
	end

	assign group_rdata  = group_reg;
	assign enable_rdata = en_reg;

	// ----------------------------------------
	// Priority storage
	// ----------------------------------------
	// Only the arbitrated level bits are kept; the low byte bits cost no flops
	vip_prio_mem u_mem (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.wr_en    (prio_wr),
		.wr_idx   (prio_idx),
		.wr_data  (prio_wdata),
		.rd_idx   (prio_idx),
		.rd_data  (prio_rdata),
		.lvl_flat (lvl_flat)
	);

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	logic [VIP_NSRC-1:0]  pend;
	logic                 best_found;
	logic [VIP_IDX_W-1:0] best_idx;
	vip_lvl_t             best_lvl;
	vip_lvl_t             best_pre;
	vip_lvl_t             pre_mask;
	logic [2:0]           sub_bits;

	assign pend = src_irq & en_reg;

	// ----------------------------------------
	// Grouping decode
	// ----------------------------------------
	// Grouping g leaves 8-g subpriority bits in the byte; three are implemented,
	// so settings of three and above leave all of them preemptive
	always_comb begin
		if (group_reg >= VIP_IMPL_BITS)
			sub_bits = 3'h0;
		else
			sub_bits = VIP_IMPL_BITS - group_reg;
		pre_mask = vip_lvl_t'(VIP_LVL_IDLE << sub_bits);
	end

	// ----------------------------------------
	// Winner search
	// ----------------------------------------
	// Strict less-than while scanning up keeps the lowest index on ties
	always_comb begin
		best_found = 1'b0;
		best_idx   = '0;
		best_lvl   = VIP_LVL_IDLE;
		for (int i = 0; i < VIP_NSRC; i++) begin
			if (pend[i] && (!best_found || lvl_flat[i*VIP_IMPL_W +: VIP_IMPL_W] < best_lvl)) begin
				best_found = 1'b1;
				best_idx   = VIP_IDX_W'(i);
				best_lvl   = lvl_flat[i*VIP_IMPL_W +: VIP_IMPL_W];
			end
		end
		best_pre = best_lvl & pre_mask;
	end

	// ----------------------------------------
	// Active handler tracking
	// ----------------------------------------
	vip_state_e           st_reg;
	vip_state_e           st_next;
	logic [VIP_IDX_W-1:0] act_reg;
	logic [VIP_IDX_W-1:0] act_next;
	vip_lvl_t             act_pre_reg;
	vip_lvl_t             act_pre_next;
	logic                 req_ok;
	logic [VIP_IDX_W-1:0] vec_reg;
	logic [VIP_IDX_W-1:0] vec_next;

	// ----------------------------------------
	// Preemption gate
	// ----------------------------------------
	// Preempt only on a strictly more urgent preemptive level; equals wait and
	// are tail-chained once irq_done returns the state to idle
	always_comb begin
		case (st_reg)
			VIP_ST_IDLE:   req_ok = best_found;
			VIP_ST_ACTIVE: req_ok = best_found && (best_pre < act_pre_reg);
			default:       req_ok = 1'b0;
		endcase
	end

	always_comb begin
		st_next      = st_reg;
		act_next     = act_reg;
		act_pre_next = act_pre_reg;
		vec_next     = best_idx;
		case (st_reg)
			VIP_ST_IDLE: begin
				if (irq_ack && req_ok) begin
					st_next      = VIP_ST_ACTIVE;
					act_next     = best_idx;
					act_pre_next = best_pre;
				end
			end
			VIP_ST_ACTIVE: begin
				// Nesting depth is the core's business; this tracks the innermost only
				if (irq_ack && req_ok) begin
					act_next     = best_idx;
					act_pre_next = best_pre;
				end else if (irq_done) begin
					st_next = VIP_ST_IDLE;
				end
			end
			default: st_next = VIP_ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Handler state registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg      <= VIP_ST_IDLE;
			act_reg     <= '0;
			act_pre_reg <= VIP_LVL_IDLE;
			vec_reg     <= '0;
		end else begin
			st_reg      <= st_next;
			act_reg     <= act_next;
			act_pre_reg <= act_pre_next;
			vec_reg     <= vec_next;
		end
	end

	// ----------------------------------------
	// Outputs to the core
	// ----------------------------------------
	// Request stays combinational so an ack can land in the cycle it rises;
	// the vector is registered and therefore trails the request by one cycle
	assign irq_req    = req_ok;
	assign irq_vec    = vec_reg;
	assign irq_active = (st_reg == VIP_ST_ACTIVE);
	assign active_vec = act_reg;
endmodule

// >>> verif/vip_top_properties.sv
`timescale 1ns/10ps
module vip_top_properties
	import vip_pkg::*;
(
	input wire logic                mclk,         // Clock
	input wire logic                reset_n,      // Reset
	input wire logic [VIP_NSRC-1:0] src_irq,      // Sources
	input wire logic                en_set,       // Enable pulse
	input wire logic                en_clr,       // Disable pulse
	input wire logic [4:0]          en_idx,       // Enable index
	input wire logic                group_wr,     // Grouping pulse
	input wire logic [2:0]          group_wdata,  // Grouping in
	input wire logic [2:0]          group_rdata,  // Grouping out
	input wire logic [VIP_NSRC-1:0] enable_rdata, // Enables
	input wire logic [7:0]          prio_rdata,   // Priority out
	input wire logic                irq_req,      // Request
	input wire logic                irq_ack,      // Take
	input wire logic                irq_done,     // End
	input wire logic                irq_active    // Handler on
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	chk_clr_blocks: assert property (en_clr |=> !enable_rdata[$past(en_idx)]) else $error("clear missed");
	chk_set_passes: assert property (en_set && !en_clr |=> enable_rdata[$past(en_idx)]) else $error("set missed");
	chk_group_read: assert property (group_wr |=> group_rdata == $past(group_wdata)) else $error("grouping bad");
	chk_low_zero: assert property (prio_rdata[4:0] == 5'h00) else $error("low bits set");
	chk_masked_quiet: assert property (!(|(src_irq & enable_rdata)) |-> !irq_req) else $error("masked req");
	chk_idle_request: assert property (!irq_active && |(src_irq & enable_rdata) |-> irq_req) else $error("no req");
	chk_ack_takes: assert property (irq_ack && irq_req && !irq_active |=> irq_active) else $error("ack lost");
	chk_done_idles: assert property (irq_done && !irq_ack |=> !irq_active) else $error("done lost");
endmodule

// >>> verif/vip_core_model.sv
`timescale 1ns/10ps
module vip_core_model (
	input  wire logic mclk,       // Clock
	input  wire logic reset_n,    // Reset
	input  wire logic go,         // Accept requests
	input  wire logic irq_req,    // Request
	input  wire logic irq_active, // Handler on
	output logic      irq_ack,    // Take pulse
	output logic      irq_done    // End pulse
);
	logic [3:0] cnt_reg;
	// Fixed handler span leaves room to provoke a nested request
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_ack  <= 1'b0;
			irq_done <= 1'b0;
			cnt_reg  <= 4'h0;
		end else begin
			irq_ack  <= go && irq_req && !irq_ack;
			irq_done <= go && irq_active && cnt_reg == 4'h9;
			cnt_reg  <= (irq_ack || !irq_active) ? 4'h0 : cnt_reg + 4'h1;
		end
	end
endmodule

// >>> verif/tb_vectored_interrupt_prioritizer.sv
`timescale 1ns/10ps
module tb_vectored_interrupt_prioritizer import vip_pkg::*;;
	logic        mclk, reset_n, en_set, en_clr, prio_wr, group_wr, go;
	logic        irq_req, irq_ack, irq_done, irq_active;
	logic [31:0] src_irq, enable_rdata;
	logic [4:0]  en_idx, prio_idx, irq_vec, active_vec;
	logic [7:0]  prio_wdata, prio_rdata;
	logic [2:0]  group_wdata, group_rdata;
	int          n_errors = 0;
	int          n_compared = 0;
	vip_top dut (.*);
	vip_core_model core (.*);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic tick(int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (exp !== got) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cfg(int s, logic [7:0] p);
		prio_idx = s[4:0];
		prio_wdata = p;
		en_idx = s[4:0];
		{prio_wr, en_set} = 2'b11;
		tick();
		{prio_wr, en_set} = 2'b00;
		tick();
	endtask
	task automatic wait_act(logic v);
		int k;
		for (k = 0; irq_active !== v && k < 40; k++) tick();
		check("irq_active", v, irq_active);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic s_enable();
		cfg(4, 8'hff);
		src_irq[4] = 1'b1;
		#1;
		check("irq_req", 1, irq_req);
		tick();
		check("irq_vec", 4, irq_vec);
		check("prio_rdata", 8'he0, prio_rdata);
		en_clr = 1'b1;
		tick();
		en_clr = 1'b0;
		check("irq_req", 0, irq_req);
		check("enable_rdata", 0, enable_rdata);
		src_irq[4] = 1'b0;
	endtask
	task automatic s_order();
		int exp [3] = '{20, 31, 3};
		cfg(31, 8'h20);
		cfg(3, 8'h40);
		cfg(20, 8'h3f);
		src_irq = 32'h8010_0008;
		foreach (exp[i]) begin
			wait_act(1'b1);
			check("active_vec", exp[i], active_vec);
			src_irq[active_vec] = 1'b0;
			wait_act(1'b0);
		end
		check("prio_rdata", 8'h20, prio_rdata);
	endtask
	task automatic s_group();
		logic [2:0] g [3] = '{3'h1, 3'h3, 3'h7};
		cfg(5, 8'ha0);
		cfg(6, 8'h80);
		foreach (g[i]) begin
			group_wdata = g[i];
			group_wr = 1'b1;
			tick();
			group_wr = 1'b0;
			check("group_rdata", g[i], group_rdata);
			src_irq[5] = 1'b1;
			wait_act(1'b1);
			src_irq[6] = 1'b1;
			tick(4);
			check("active_vec", (g[i] >= 3'h3) ? 6 : 5, active_vec);
			src_irq[6:5] = 2'b00;
			wait_act(1'b0);
		end
	endtask
	task automatic results();
		if (n_errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		{reset_n, src_irq, en_set, en_clr, en_idx, prio_wr, prio_idx, prio_wdata} = '0;
		{group_wr, group_wdata, go} = '0;
		repeat (16) @(posedge mclk);
		#1 reset_n = 1'b1;
		check("group_rdata", 3, group_rdata);
		s_enable();
		go = 1'b1;
		s_order();
		s_group();
		results();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		n_errors++;
		results();
	end
endmodule
bind vip_top vip_top_properties chk (.*);
